// [dv/ast_assertions.sv]
// Port checker of the serial transceiver, bound to its top module.
`timescale 1ns/1ps
module ast_chk
  import ast_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic o_serial_out_pin,
  input wire logic o_serial_out_oe_n,
  input wire logic o_alt_serial_out_pin,
  input wire logic o_alt_serial_out_oe_n,
  input wire logic o_tx_irq_flag,
  input wire logic o_rx_irq_flag
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  logic mode_wr;
  // Mode register write decode
  assign mode_wr = i_wr && (i_addr == AST_MODE_ADDR);
  property p_alt_sel;
    !o_alt_serial_out_oe_n |-> o_serial_out_oe_n && o_serial_out_pin;
  endproperty
  a_alt_sel: assert property (p_alt_sel) else $error("primary pin busy on alt");
  property p_prim_sel;
    !o_serial_out_oe_n |-> o_alt_serial_out_oe_n && o_alt_serial_out_pin;
  endproperty
  a_prim_sel: assert property (p_prim_sel) else $error("alt pin busy on primary");
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_tx_start;
    o_tx_irq_flag |-> (!o_serial_out_oe_n && !o_serial_out_pin)
      || (!o_alt_serial_out_oe_n && !o_alt_serial_out_pin);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx event without start");
  property p_tx_pulse;
    o_tx_irq_flag |=> !o_tx_irq_flag;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx event too long");
  property p_rx_pulse;
    o_rx_irq_flag |=> !o_rx_irq_flag;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx event too long");
  property p_off;
    mode_wr && !i_wdata[AST_MODE_ON_BIT] |=> (o_serial_out_oe_n && o_alt_serial_out_oe_n
      && !o_tx_irq_flag) [*2];
  endproperty
  a_off: assert property (p_off) else $error("pins kept after disable");
  property p_on;
    mode_wr && i_wdata[AST_MODE_ON_BIT] && !i_wdata[AST_ALT_PIN_BIT] |=> !o_serial_out_oe_n;
  endproperty
  a_on: assert property (p_on) else $error("pin not driven after enable");
  c_tx: cover property (o_tx_irq_flag);
  c_rx: cover property (o_rx_irq_flag);
  c_alt: cover property (!o_alt_serial_out_oe_n);
endmodule // ast_chk
bind ast_uart ast_chk u_chk (.i_ref_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_serial_out_pin, .o_serial_out_oe_n, .o_alt_serial_out_pin,
  .o_alt_serial_out_oe_n, .o_tx_irq_flag, .o_rx_irq_flag);

// [dv/ast_remote.sv]
// Far-end serial device model: sends frames, samples frames seen on the line.
`timescale 1ns/1ps
module ast_remote #(parameter int BIT_CLKS = 32) (
  input wire logic i_ref_clk,
  input wire logic i_line,
  output logic o_line
);
  logic [8:0] rx_bits;
  int frames;
  initial begin
    o_line = 1'b1;
    frames = 0;
    rx_bits = 9'h000;
  end
  // Low start, then n bits LSB first; line rests high after the frame
  task automatic send(input logic [9:0] bits, input int n);
    int i;
    o_line <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_ref_clk);
    for (i = 0; i < n; i++) begin
      o_line <= bits[i];
      repeat (BIT_CLKS) @(posedge i_ref_clk);
    end
    o_line <= 1'b1;
    // One idle clock so a following frame never drives the line twice in one step
    @(posedge i_ref_clk);
  endtask
  // Mid-bit sampling; only nine bits kept so a back-to-back start is not missed
  always begin : rx_proc
    int k;
    @(negedge i_line);
    repeat (BIT_CLKS / 2) @(posedge i_ref_clk);
    if (i_line == 1'b0) begin
      for (k = 0; k < 9; k++) begin
        repeat (BIT_CLKS) @(posedge i_ref_clk);
        rx_bits[k] = i_line;
      end
      frames++;
    end
  end
endmodule // ast_remote

// [dv/tb.sv]
// Self-checking bench: register tasks, far-end frames, pin and status checks.
`timescale 1ns/1ps
module tb;
  import ast_pkg::*;
  logic clk = 1'b0;
  logic rst_n, wr, rd, rx_line, alt_rx, line;
  logic tx_pin, tx_oe_n, atx_pin, atx_oe_n, tx_irq, rx_irq, p;
  logic [15:0] addr, wdata, rdata;
  int err_count, checks_done, tx_irqs, rx_irqs, f, base;
  ast_uart uut (.i_ref_clk(clk), .i_resetn(rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_serial_in_pin(rx_line),
    .i_alt_serial_in_pin(alt_rx), .o_serial_out_pin(tx_pin), .o_serial_out_oe_n(tx_oe_n),
    .o_alt_serial_out_pin(atx_pin), .o_alt_serial_out_oe_n(atx_oe_n),
    .o_tx_irq_flag(tx_irq), .o_rx_irq_flag(rx_irq));
  ast_remote #(.BIT_CLKS(32)) u_rem (.i_ref_clk(clk), .i_line(line), .o_line(rx_line));
  // Pulled-up line: high whenever the module does not drive it
  assign line = tx_oe_n ? 1'b1 : tx_pin;
  always #10 clk = ~clk;
  // Event pulses counted as they pass
  always @(posedge clk) begin
    if (tx_irq === 1'b1) tx_irqs++;
    if (rx_irq === 1'b1) rx_irqs++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Data sits in the cycle after the strobe only
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic wait_frames(input int n);
    int t;
    t = 0;
    while (u_rem.frames < n && t < 4000) begin
      @(posedge clk);
      t++;
    end
    chk(16'(u_rem.frames), 16'(n));
    // Let the parity and stop bits finish before anything is reconfigured
    repeat (64) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("err_count=%0d checks_done=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(20 * 60000);
    err_count++;
    print_verdict;
  end
  initial begin
    {rst_n, wr, rd, addr, wdata, alt_rx} = {3'b000, 32'h0, 1'b1};
    {err_count, checks_done, tx_irqs, rx_irqs} = 128'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state: disabled, 8N1, idle flags set, unmapped reads zero
    rd_chk(AST_MODE_ADDR, 16'h0000);
    rd_chk(AST_STATUS_ADDR, 16'h0110);
    rd_chk(AST_BAUD_ADDR, 16'h0000);
    rd_chk(16'h0216, 16'h0000);
    chk({15'h0, tx_oe_n}, 16'h0001);
    wr_reg(AST_BAUD_ADDR, 16'h0001);
    wr_reg(AST_MODE_ADDR, 16'h8000);
    #1 chk({14'h0, tx_oe_n, line}, 16'h0001);
    wr_reg(AST_STATUS_ADDR, 16'h0400);
    wr_reg(AST_TXDATA_ADDR, 16'h0055);
    wait_frames(1);
    chk({7'h0, u_rem.rx_bits}, 16'h0155);
    chk(16'(tx_irqs), 16'h0001);
    // Formats 8E, 8O and 9N: the ninth bit is parity or data bit 8
    for (f = 1; f < 4; f++) begin
      wr_reg(AST_MODE_ADDR, 16'h8000 | (16'(f) << 1));
      wr_reg(AST_TXDATA_ADDR, (f == 3) ? 16'h01A5 : 16'h00A5);
      p = (f == 1) ? ^8'hA5 : 1'b1;
      wait_frames(f + 1);
      chk({7'h0, p, u_rem.rx_bits[7:0]}, {7'h0, u_rem.rx_bits});
      chk({8'h0, u_rem.rx_bits[7:0]}, 16'h00A5);
    end
    // Fill queue with sending held off, overfill, then release
    wr_reg(AST_MODE_ADDR, 16'h8000);
    wr_reg(AST_STATUS_ADDR, 16'h0000);
    for (f = 1; f < 6; f++) wr_reg(AST_TXDATA_ADDR, 16'(f * 16'h0011));
    rd_chk(AST_STATUS_ADDR, 16'h0310);
    wr_reg(AST_STATUS_ADDR, 16'h8400);
    wait_frames(8);
    chk({7'h0, u_rem.rx_bits}, 16'h0144);
    chk(16'(tx_irqs), 16'h0005);
    repeat (400) @(posedge clk);
    chk(16'(u_rem.frames), 16'h0008);
    // Three words in with event code 10; pops in order
    wr_reg(AST_STATUS_ADDR, 16'h0480);
    u_rem.send(10'h13C, 9);
    u_rem.send(10'h1C3, 9);
    u_rem.send(10'h15A, 9);
    repeat (4) @(posedge clk);
    chk(16'(rx_irqs), 16'h0001);
    rd_chk(AST_STATUS_ADDR, 16'h0591);
    rd_chk(AST_RXDATA_ADDR, 16'h003C);
    rd_chk(AST_RXDATA_ADDR, 16'h00C3);
    rd_chk(AST_RXDATA_ADDR, 16'h005A);
    rd_chk(AST_STATUS_ADDR, 16'h0590);
    rd_chk(AST_RXDATA_ADDR, 16'h005A);
    u_rem.send(10'h0F0, 9);
    repeat (64) @(posedge clk);
    rd_chk(AST_STATUS_ADDR, 16'h0595);
    rd_chk(AST_RXDATA_ADDR, 16'h00F0);
    rd_chk(AST_STATUS_ADDR, 16'h0590);
    // Five words into a four-word queue: overrun stands until software clears it
    for (f = 0; f < 5; f++) u_rem.send(10'h100 | 10'(f), 9);
    chk(16'(rx_irqs), 16'h0002);
    rd_chk(AST_STATUS_ADDR, 16'h0593);
    wr_reg(AST_STATUS_ADDR, 16'h0480);
    rd_chk(AST_STATUS_ADDR, 16'h0591);
    rd_chk(AST_RXDATA_ADDR, 16'h0000);
    // Break: line low for 14 bit times, no transmit event
    wr_reg(AST_STATUS_ADDR, 16'h0C80);
    repeat (448) @(posedge clk);
    chk({15'h0, line}, 16'h0000);
    chk(16'(tx_irqs), 16'h0005);
    wr_reg(AST_STATUS_ADDR, 16'h0480);
    repeat (64) @(posedge clk);
    chk({15'h0, line}, 16'h0001);
    // Disable in mid-frame with a word still queued
    wr_reg(AST_TXDATA_ADDR, 16'h00AA);
    wr_reg(AST_TXDATA_ADDR, 16'h00BB);
    repeat (60) @(posedge clk);
    wr_reg(AST_MODE_ADDR, 16'h0007);
    #1 chk({15'h0, line}, 16'h0001);
    rd_chk(AST_STATUS_ADDR, 16'h0190);
    rd_chk(AST_MODE_ADDR, 16'h0007);
    rd_chk(AST_BAUD_ADDR, 16'h0001);
    repeat (400) @(posedge clk);
    base = u_rem.frames;
    wr_reg(AST_MODE_ADDR, 16'h8000);
    wr_reg(AST_STATUS_ADDR, 16'h0400);
    wr_reg(AST_TXDATA_ADDR, 16'h0096);
    wait_frames(base + 1);
    chk({7'h0, u_rem.rx_bits}, 16'h0196);
    wr_reg(AST_MODE_ADDR, 16'h8400);
    #1 chk({14'h0, tx_oe_n, atx_oe_n}, 16'h0002);
    chk({15'h0, atx_pin}, 16'h0001);
    print_verdict;
  end
endmodule // tb

// [hw/ast_uart.sv]
// Asynchronous serial transceiver: registers, baud, transmit and receive paths.
`timescale 1ns/1ps
module ast_uart
  import ast_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_serial_in_pin,
  input wire logic i_alt_serial_in_pin,
  output logic o_serial_out_pin,
  output logic o_serial_out_oe_n,
  output logic o_alt_serial_out_pin,
  output logic o_alt_serial_out_oe_n,
  output logic o_tx_irq_flag,
  output logic o_rx_irq_flag
);

  // Parity bit for a data byte given the format
  function automatic logic par_of(input logic [7:0] d, input logic [1:0] fmt);
    par_of = (fmt == AST_FMT_8O) ? ~(^d) : (^d);
  endfunction

  // Number of data bits minus one for the format
  function automatic logic [3:0] last_bit(input logic [1:0] fmt);
    last_bit = (fmt == AST_FMT_9N) ? 4'h8 : 4'h7;
  endfunction

  logic [15:0] mode_reg;
  logic [15:0] baud_divisor_reg;
  logic tx_irq_select_reg;
  logic tx_break_force_reg;
  logic tx_allow_reg;
  logic [1:0] rx_irq_select_reg;
  logic addr_detect_on_reg;
  logic rx_overrun_flag_reg;
  logic [15:0] rdata_reg;

  logic module_on;
  logic alt_pin_select;
  logic [1:0] frame_format_sel;
  logic stop_count_sel;
  logic wr_mode, wr_status, wr_tx, wr_baud, rd_rx;

  assign module_on = mode_reg[AST_MODE_ON_BIT];
  assign alt_pin_select = mode_reg[AST_ALT_PIN_BIT];
  assign frame_format_sel = mode_reg[AST_FMT_LSB +: 2];
  assign stop_count_sel = mode_reg[AST_STOP_BIT];
  assign wr_mode = i_wr && (i_addr == AST_MODE_ADDR);
  assign wr_status = i_wr && (i_addr == AST_STATUS_ADDR);
  assign wr_tx = i_wr && (i_addr == AST_TXDATA_ADDR);
  assign wr_baud = i_wr && (i_addr == AST_BAUD_ADDR);
  assign rd_rx = i_rd && (i_addr == AST_RXDATA_ADDR);

  // Mode and divisor: only software and reset touch them, never disable
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_reg <= AST_MODE_RST;
      baud_divisor_reg <= AST_BAUD_RST;
    end else begin
      if (wr_mode) begin
        mode_reg <= i_wdata;
      end
      if (wr_baud) begin
        baud_divisor_reg <= i_wdata;
      end
    end
  end

  // Status control bits; selects survive disable, allow and break do not
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_irq_select_reg <= AST_STATUS_RST[AST_TX_ISEL_BIT];
      rx_irq_select_reg <= AST_STATUS_RST[AST_RX_ISEL_LSB +: 2];
      addr_detect_on_reg <= AST_STATUS_RST[AST_ADDR_DET_BIT];
      tx_allow_reg <= AST_STATUS_RST[AST_TX_ALLOW_BIT];
      tx_break_force_reg <= AST_STATUS_RST[AST_TX_BRK_BIT];
    end else begin
      if (wr_status) begin
        tx_irq_select_reg <= i_wdata[AST_TX_ISEL_BIT];
        rx_irq_select_reg <= i_wdata[AST_RX_ISEL_LSB +: 2];
        addr_detect_on_reg <= i_wdata[AST_ADDR_DET_BIT];
      end
      if (!module_on) begin
        tx_allow_reg <= 1'b0;
        tx_break_force_reg <= 1'b0;
      end else if (wr_status) begin
        tx_allow_reg <= i_wdata[AST_TX_ALLOW_BIT];
        tx_break_force_reg <= i_wdata[AST_TX_BRK_BIT];
      end
    end
  end

  // Sixteen-times baud tick; counter held cleared while disabled
  logic [15:0] baud_cnt_reg;
  logic tick;
  assign tick = module_on && (baud_cnt_reg == baud_divisor_reg);
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      baud_cnt_reg <= 16'h0000;
    end else if (!module_on || tick) begin
      baud_cnt_reg <= 16'h0000;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 16'h0001;
    end
  end

  // ---------------- Transmit path ----------------
  logic [8:0] txq_mem [AST_QDEPTH];
  logic [1:0] txq_wp_reg, txq_rp_reg;
  logic [2:0] txq_cnt_reg;
  logic tx_queue_full;
  logic tx_load;
  logic tx_push;
  ast_state_t tx_state_reg;
  logic [8:0] tx_shifter;
  logic [3:0] tx_tick_reg;
  logic [3:0] tx_idx_reg;
  logic tx_bit_reg;
  logic tx_bit_end;
  logic tx_irq_reg;

  assign tx_queue_full = (txq_cnt_reg == AST_QFULL);
  assign tx_push = wr_tx && module_on && !tx_queue_full;
  // Break holds the shifter idle so no load and no transmit event occur
  assign tx_load = module_on && tx_allow_reg && !tx_break_force_reg
                   && (tx_state_reg == AST_ST_IDLE) && (txq_cnt_reg != 3'h0);
  assign tx_bit_end = tick && (tx_tick_reg == AST_TICKS_LAST);

  // Transmit queue pointers; disable or reset empties it
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      txq_wp_reg <= 2'h0;
      txq_rp_reg <= 2'h0;
      txq_cnt_reg <= 3'h0;
    end else if (!module_on) begin
      txq_wp_reg <= 2'h0;
      txq_rp_reg <= 2'h0;
      txq_cnt_reg <= 3'h0;
    end else begin
      if (tx_push) begin
        txq_wp_reg <= txq_wp_reg + 2'h1;
      end
      if (tx_load) begin
        txq_rp_reg <= txq_rp_reg + 2'h1;
      end
      if (tx_push && !tx_load) begin
        txq_cnt_reg <= txq_cnt_reg + 3'h1;
      end else if (tx_load && !tx_push) begin
        txq_cnt_reg <= txq_cnt_reg - 3'h1;
      end
    end
  end

  // Queue storage: nine low bits of the written word
  always_ff @(posedge i_ref_clk) begin
    if (tx_push) begin
      txq_mem[txq_wp_reg] <= i_wdata[8:0];
    end
  end

  // Transmit shifter; the bit timer restarts at load so start goes out at once
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_state_reg <= AST_ST_IDLE;
      tx_shifter <= 9'h000;
      tx_tick_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      tx_bit_reg <= 1'b1;
    end else if (!module_on) begin
      tx_state_reg <= AST_ST_IDLE;
      tx_tick_reg <= 4'h0;
      tx_idx_reg <= 4'h0;
      tx_bit_reg <= 1'b1;
    end else if (tx_load) begin
      tx_shifter <= txq_mem[txq_rp_reg];
      tx_state_reg <= AST_ST_START;
      tx_tick_reg <= 4'h0;
      tx_bit_reg <= 1'b0;
    end else if (tick) begin
      tx_tick_reg <= tx_tick_reg + 4'h1;
      if (tx_bit_end) begin
        case (tx_state_reg)
          AST_ST_START: begin
            tx_state_reg <= AST_ST_DATA;
            tx_idx_reg <= 4'h0;
            tx_bit_reg <= tx_shifter[0];
          end
          AST_ST_DATA: begin
            // At or past the last bit, so a format change mid-frame cannot index off the end
            if (tx_idx_reg >= last_bit(frame_format_sel)) begin
              if (frame_format_sel == AST_FMT_8E || frame_format_sel == AST_FMT_8O) begin
                tx_state_reg <= AST_ST_PAR;
                tx_bit_reg <= par_of(tx_shifter[7:0], frame_format_sel);
              end else begin
                tx_state_reg <= AST_ST_STOP;
                tx_idx_reg <= 4'h0;
                tx_bit_reg <= 1'b1;
              end
            end else begin
              tx_idx_reg <= tx_idx_reg + 4'h1;
              tx_bit_reg <= tx_shifter[tx_idx_reg + 4'h1];
            end
          end
          AST_ST_PAR: begin
            tx_state_reg <= AST_ST_STOP;
            tx_idx_reg <= 4'h0;
            tx_bit_reg <= 1'b1;
          end
          AST_ST_STOP: begin
            if (stop_count_sel && tx_idx_reg == 4'h0) begin
              tx_idx_reg <= 4'h1;
            end else begin
              tx_state_reg <= AST_ST_IDLE;
            end
          end
          default: begin
            tx_state_reg <= AST_ST_IDLE;
            tx_bit_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  // Transmit event pulse: every load, or only the load that empties the queue
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tx_irq_reg <= 1'b0;
    end else begin
      tx_irq_reg <= tx_load && (!tx_irq_select_reg || (txq_cnt_reg == 3'h1 && !tx_push));
    end
  end

  // Pin steering; released to port control while disabled
  logic tx_line;
  assign tx_line = tx_break_force_reg ? 1'b0 : tx_bit_reg;
  assign o_serial_out_pin = alt_pin_select ? 1'b1 : tx_line;
  assign o_alt_serial_out_pin = alt_pin_select ? tx_line : 1'b1;
  assign o_serial_out_oe_n = !(module_on && !alt_pin_select);
  assign o_alt_serial_out_oe_n = !(module_on && alt_pin_select);

  // ---------------- Receive path ----------------
  logic rx_line;
  logic rx_prev_reg;
  assign rx_line = alt_pin_select ? i_alt_serial_in_pin : i_serial_in_pin;

  logic [10:0] rxq_mem [AST_QDEPTH];
  logic [1:0] rxq_wp_reg, rxq_rp_reg;
  logic [2:0] rxq_cnt_reg;
  ast_state_t rx_state_reg;
  logic [8:0] rx_shifter;
  logic [3:0] rx_tick_reg;
  logic [3:0] rx_idx_reg;
  logic rx_rx_parity_err_flag_reg, rx_rx_frame_err_flag_reg;
  logic rx_done;
  logic rx_pop;
  logic rx_push;
  logic rx_irq_reg;
  logic rx_sample;
  logic rx_stop_last;

  assign rx_sample = tick && (rx_tick_reg == AST_TICKS_MID);
  assign rx_stop_last = !stop_count_sel || (rx_idx_reg == 4'h1);
  assign rx_done = rx_sample && (rx_state_reg == AST_ST_STOP) && rx_stop_last;
  assign rx_pop = rd_rx && (rxq_cnt_reg != 3'h0);
  assign rx_push = rx_done && (rxq_cnt_reg != AST_QFULL);

  // Receive framer; an overrun freezes it until software clears the flag
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_state_reg <= AST_ST_IDLE;
      rx_shifter <= 9'h000;
      rx_tick_reg <= 4'h0;
      rx_idx_reg <= 4'h0;
      rx_rx_parity_err_flag_reg <= 1'b0;
      rx_rx_frame_err_flag_reg <= 1'b0;
      rx_prev_reg <= 1'b1;
    end else if (!module_on) begin
      rx_state_reg <= AST_ST_IDLE;
      rx_tick_reg <= 4'h0;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_prev_reg <= rx_line;
      if (rx_state_reg == AST_ST_IDLE) begin
        // Needs a high-to-low step, so a long break is not a new start
        if (!rx_line && rx_prev_reg && !rx_overrun_flag_reg) begin
          rx_state_reg <= AST_ST_START;
          rx_tick_reg <= 4'h0;
          rx_rx_parity_err_flag_reg <= 1'b0;
          rx_rx_frame_err_flag_reg <= 1'b0;
          rx_shifter <= 9'h000;
        end
      end else if (tick) begin
        rx_tick_reg <= rx_tick_reg + 4'h1;
        if (rx_sample) begin
          case (rx_state_reg)
            AST_ST_START: begin
              if (rx_line) begin
                rx_state_reg <= AST_ST_IDLE; // Glitch, not a start
              end else begin
                rx_state_reg <= AST_ST_DATA;
                rx_idx_reg <= 4'h0;
              end
            end
            AST_ST_DATA: begin
              rx_shifter[rx_idx_reg] <= rx_line;
              if (rx_idx_reg >= last_bit(frame_format_sel)) begin
                if (frame_format_sel == AST_FMT_8E || frame_format_sel == AST_FMT_8O) begin
                  rx_state_reg <= AST_ST_PAR;
                end else begin
                  rx_state_reg <= AST_ST_STOP;
                  rx_idx_reg <= 4'h0;
                end
              end else begin
                rx_idx_reg <= rx_idx_reg + 4'h1;
              end
            end
            AST_ST_PAR: begin
              rx_rx_parity_err_flag_reg <= (rx_line != par_of(rx_shifter[7:0], frame_format_sel));
              rx_state_reg <= AST_ST_STOP;
              rx_idx_reg <= 4'h0;
            end
            AST_ST_STOP: begin
              if (rx_stop_last) begin
                rx_state_reg <= AST_ST_IDLE;
              end else begin
                rx_idx_reg <= 4'h1;
              end
              if (!rx_line) begin
                rx_rx_frame_err_flag_reg <= 1'b1;
              end
            end
            default: begin
              rx_state_reg <= AST_ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // Receive queue pointers; disable or reset empties it
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rxq_wp_reg <= 2'h0;
      rxq_rp_reg <= 2'h0;
      rxq_cnt_reg <= 3'h0;
    end else if (!module_on) begin
      rxq_wp_reg <= 2'h0;
      rxq_rp_reg <= 2'h0;
      rxq_cnt_reg <= 3'h0;
    end else begin
      if (rx_push) begin
        rxq_wp_reg <= rxq_wp_reg + 2'h1;
      end
      if (rx_pop) begin
        rxq_rp_reg <= rxq_rp_reg + 2'h1;
      end
      if (rx_push && !rx_pop) begin
        rxq_cnt_reg <= rxq_cnt_reg + 3'h1;
      end else if (rx_pop && !rx_push) begin
        rxq_cnt_reg <= rxq_cnt_reg - 3'h1;
      end
    end
  end

  // Stored word carries its own error flags so they follow the head
  always_ff @(posedge i_ref_clk) begin
    if (rx_push) begin
      rxq_mem[rxq_wp_reg] <= {rx_rx_parity_err_flag_reg, rx_rx_frame_err_flag_reg || !rx_line, rx_shifter};
    end
  end

  // Overrun: set wins over a software clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_overrun_flag_reg <= 1'b0;
    end else if (!module_on) begin
      rx_overrun_flag_reg <= 1'b0;
    end else if (rx_done && rxq_cnt_reg == AST_QFULL) begin
      rx_overrun_flag_reg <= 1'b1;
    end else if (wr_status && !i_wdata[AST_RX_OVERRUN_FLAG_BIT]) begin
      rx_overrun_flag_reg <= 1'b0;
    end
  end

  // Receive event pulse by select code and resulting fill level
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_irq_reg <= 1'b0;
    end else begin
      case (rx_irq_select_reg)
        2'h2: rx_irq_reg <= rx_push && (rxq_cnt_reg - (rx_pop ? 3'h1 : 3'h0)) == 3'h2;
        2'h3: rx_irq_reg <= rx_push && !rx_pop && rxq_cnt_reg == AST_QTHREE;
        default: rx_irq_reg <= rx_push;
      endcase
    end
  end

  assign o_tx_irq_flag = tx_irq_reg;
  assign o_rx_irq_flag = rx_irq_reg;

  // ---------------- Read port ----------------
  logic [10:0] rx_head;
  logic rx_have;
  logic [15:0] status_word;
  assign rx_head = rxq_mem[rxq_rp_reg];
  assign rx_have = (rxq_cnt_reg != 3'h0);

  // Last word handed out; an empty read repeats it rather than an unwritten slot
  logic [8:0] rx_last_reg;
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rx_last_reg <= 9'h000;
    end else if (!module_on) begin
      rx_last_reg <= 9'h000;
    end else if (rx_pop) begin
      rx_last_reg <= rx_head[8:0];
    end
  end

  // Status image; parity and frame error bits only describe a word that is present
  always_comb begin
    status_word = 16'h0000;
    status_word[AST_TX_ISEL_BIT] = tx_irq_select_reg;
    status_word[AST_TX_BRK_BIT] = tx_break_force_reg;
    status_word[AST_TX_ALLOW_BIT] = tx_allow_reg;
    status_word[AST_TX_FULL_BIT] = tx_queue_full;
    status_word[AST_TX_EMPTY_BIT] = (tx_state_reg == AST_ST_IDLE);
    status_word[AST_RX_ISEL_LSB +: 2] = rx_irq_select_reg;
    status_word[AST_ADDR_DET_BIT] = addr_detect_on_reg;
    status_word[AST_RX_IDLE_BIT] = (rx_state_reg == AST_ST_IDLE);
    status_word[AST_RX_PARITY_ERR_FLAG_BIT] = rx_have && rx_head[10];
    status_word[AST_RX_FRAME_ERR_FLAG_BIT] = rx_have && rx_head[9];
    status_word[AST_RX_OVERRUN_FLAG_BIT] = rx_overrun_flag_reg;
    status_word[AST_RXDA_BIT] = rx_have;
  end

  // Read data registered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_reg <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        AST_MODE_ADDR: rdata_reg <= mode_reg;
        AST_STATUS_ADDR: rdata_reg <= status_word;
        AST_RXDATA_ADDR: rdata_reg <= {7'h00, (rx_have ? rx_head[8:0] : rx_last_reg)};
        AST_BAUD_ADDR: rdata_reg <= baud_divisor_reg;
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end
  assign o_rdata = rdata_reg;

endmodule // ast_uart

// [pkg/ast_pkg.sv]
// Constants, register map and types of the asynchronous serial transceiver.
package ast_pkg;
  localparam logic [15:0] AST_MODE_ADDR = 16'h020C;
  localparam logic [15:0] AST_STATUS_ADDR = 16'h020E;
  localparam logic [15:0] AST_TXDATA_ADDR = 16'h0210;
  localparam logic [15:0] AST_RXDATA_ADDR = 16'h0212;
  localparam logic [15:0] AST_BAUD_ADDR = 16'h0214;
  // Mode register fields
  localparam int AST_MODE_ON_BIT = 15;
  localparam int AST_ALT_PIN_BIT = 10;
  localparam int AST_FMT_LSB = 1;
  localparam int AST_STOP_BIT = 0;
  localparam logic [15:0] AST_MODE_RST = 16'h0000;
  // Status register fields
  localparam int AST_TX_ISEL_BIT = 15;
  localparam int AST_TX_BRK_BIT = 11;
  localparam int AST_TX_ALLOW_BIT = 10;
  localparam int AST_TX_FULL_BIT = 9;
  localparam int AST_TX_EMPTY_BIT = 8;
  localparam int AST_RX_ISEL_LSB = 6;
  localparam int AST_ADDR_DET_BIT = 5;
  localparam int AST_RX_IDLE_BIT = 4;
  localparam int AST_RX_PARITY_ERR_FLAG_BIT = 3;
  localparam int AST_RX_FRAME_ERR_FLAG_BIT = 2;
  localparam int AST_RX_OVERRUN_FLAG_BIT = 1;
  localparam int AST_RXDA_BIT = 0;
  localparam logic [15:0] AST_STATUS_RST = 16'h0110;
  localparam logic [15:0] AST_BAUD_RST = 16'h0000;
  // Queue geometry and bit timing
  localparam int AST_QDEPTH = 4;
  localparam logic [2:0] AST_QFULL = 3'h4;
  localparam logic [2:0] AST_QTHREE = 3'h3;
  localparam logic [3:0] AST_TICKS_LAST = 4'hF;
  localparam logic [3:0] AST_TICKS_MID = 4'h7;
  // Frame formats
  localparam logic [1:0] AST_FMT_8N = 2'h0;
  localparam logic [1:0] AST_FMT_8E = 2'h1;
  localparam logic [1:0] AST_FMT_8O = 2'h2;
  localparam logic [1:0] AST_FMT_9N = 2'h3;
  typedef enum logic [2:0] {
    AST_ST_IDLE = 3'b000,
    AST_ST_START = 3'b001,
    AST_ST_DATA = 3'b010,
    AST_ST_PAR = 3'b011,
    AST_ST_STOP = 3'b100
  } ast_state_t;
endpackage
